//--- verilog/rtc_date_consts.svh
/*
  Offsets, field layouts, count limits and response codes of the calendar
  date registers. Definitions only; included by bare name.
  Assumes the includer compiles it once per compilation unit.
*/
`ifndef RTC_DATE_CONSTS_SVH
`define RTC_DATE_CONSTS_SVH

// register indices; byte address is four times the index
`define RTC_IDX_WEEKDAY 12'hf34
`define RTC_IDX_MONTH 12'hf35
`define RTC_IDX_YEAR 12'hf36
`define RTC_IDX_ALARM_SEC 12'hf37

// field widths and positions
`define RTC_WEEKDAY_W 3
`define RTC_MONTH_W 5
`define RTC_MONTH_TENS_BIT 4
`define RTC_YEAR_W 8
`define RTC_ALARM_W 8

// count limits, binary and decimal coding
`define RTC_WEEKDAY_MIN 8'h01
`define RTC_WEEKDAY_MAX 8'h07
`define RTC_MONTH_MIN 8'h01
`define RTC_MONTH_MAX_BIN 8'h0c
`define RTC_MONTH_MAX_BCD 8'h12
`define RTC_YEAR_MIN 8'h00
`define RTC_YEAR_MAX_BIN 8'h63
`define RTC_YEAR_MAX_BCD 8'h99

// bus responses
`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2

`endif

//--- verilog/rtc_date_pkg.sv
/*
  Types shared by the calendar date register block.
  Assumes rtc_date_consts.svh carries all numeric constants.
*/
package rtc_date_pkg;

  // which register a bus address selects
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_WEEKDAY = 3'h1,
    SEL_MONTH = 3'h2,
    SEL_YEAR = 3'h3,
    SEL_ALARM = 3'h4
  } reg_sel_e;

  // write channel sequencer, gray along idle -> respond -> idle
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_e;

  // register images shown to the rest of the clock unit
  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] alarm_sec;
  } date_s;

endpackage : rtc_date_pkg

//--- verilog/rtc_field_step.sv
/*
  One calendar field: next count value with wrap, in binary or decimal.
  Assumes limits are given in the same coding as the current value.
*/
module rtc_field_step (
  input wire logic [7:0] cur,
  input wire logic bcd_mode,
  input wire logic [7:0] min_val,
  input wire logic [7:0] max_val,
  output logic [7:0] nxt_val,
  output logic at_max
);

  logic [7:0] inc_bin; // plain binary successor
  logic [7:0] inc_bcd; // decimal successor, ones digit carries into tens

  // successors in both codings
  always_comb begin
    inc_bin = cur + 8'h01;
    if (cur[3:0] >= 4'h9) begin
      inc_bcd = {cur[7:4] + 4'h1, 4'h0};
    end else begin
      inc_bcd = {cur[7:4], cur[3:0] + 4'h1};
    end
  end

  // an out-of-range value written by software also wraps, so a bad
  // write cannot leave the field counting through illegal codes
  assign at_max = (cur >= max_val);
  assign nxt_val = at_max ? min_val : (bcd_mode ? inc_bcd : inc_bin);

endmodule : rtc_field_step

//--- verilog/rtc_date_regs.sv
/*
  Calendar date registers of the real-time clock: weekday, month, year
  and alarm seconds, reached over an AXI4-Lite slave.
  Assumes bcd_en, clock_locked, day_tick and month_tick come from logic
  on clk (lock control and day-of-month counter), so none is synchronised.

// Summary of operation
// - counts keep their value through reset
// - date counts writable only while unlocked
// - binary or decimal counting per coding select
// - weekday lowest count is one
// - weekday in bits 2:0, values 1..7
// - weekday bits 7:3 read-only, software writes zero
// - month lowest count is one
// - binary month in bits 3:0, 1..12
// - decimal month tens bit 4, ones 3:0
// - binary year 0..0x63 in bits 6:0
// - decimal year tens 7:4, ones 3:0
// - alarm seconds writable, kept through reset
*/
`include "rtc_date_consts.svh"

module rtc_date_regs #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic bcd_en,
  input wire logic clock_locked,
  input wire logic day_tick,
  input wire logic month_tick,
  output rtc_date_pkg::date_s date,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // address to register select, shared by the write and read paths
  function automatic rtc_date_pkg::reg_sel_e reg_dec(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] idx;
    idx = a >> 2;
    if (idx == ADDR_W'(`RTC_IDX_WEEKDAY)) begin
      reg_dec = rtc_date_pkg::SEL_WEEKDAY;
    end else if (idx == ADDR_W'(`RTC_IDX_MONTH)) begin
      reg_dec = rtc_date_pkg::SEL_MONTH;
    end else if (idx == ADDR_W'(`RTC_IDX_YEAR)) begin
      reg_dec = rtc_date_pkg::SEL_YEAR;
    end else if (idx == ADDR_W'(`RTC_IDX_ALARM_SEC)) begin
      reg_dec = rtc_date_pkg::SEL_ALARM;
    end else begin
      reg_dec = rtc_date_pkg::SEL_NONE;
    end
  endfunction : reg_dec

  // count registers; deliberately outside the reset
  logic [`RTC_WEEKDAY_W-1:0] weekday_r; // weekday_value
  logic [`RTC_MONTH_W-1:0] month_r; // month_tens and month_ones
  logic [`RTC_YEAR_W-1:0] year_r; // year_tens and year_ones
  logic [`RTC_ALARM_W-1:0] alarm_sec_r; // alarm_seconds_value

  // write channel state
  rtc_date_pkg::wr_state_e wr_state_r;
  logic aw_got_r; // address taken, waiting for data
  logic w_got_r; // data taken, waiting for address
  logic [ADDR_W-1:0] waddr_r;
  logic [7:0] wbyte_r;
  logic wlane_r; // byte lane 0 enabled
  logic [1:0] bresp_r;

  // read channel state
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // live enable: the whole block freezes under clk_en low; reset holds the counts and clears the channels
  logic run;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_do; // both halves present: commit the write this cycle
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  rtc_date_pkg::reg_sel_e wr_sel;
  rtc_date_pkg::reg_sel_e rd_sel;
  logic weekday_wr;
  logic month_wr;
  logic year_wr;
  logic alarm_wr;

  // field stepping: 0 weekday, 1 month, 2 year
  logic [7:0] step_cur [3];
  logic [7:0] step_min [3];
  logic [7:0] step_max [3];
  logic [7:0] step_nxt [3];
  logic step_wrap [3];
  logic year_carry;

  assign run = clk_en && !sys_rst;
  // handshake outputs are combinational; readies drop while frozen so
  // no beat is accepted on a cycle the registers cannot take it
  assign awready = run && (wr_state_r == rtc_date_pkg::WR_IDLE) && !aw_got_r;
  assign wready = run && (wr_state_r == rtc_date_pkg::WR_IDLE) && !w_got_r;
  assign bvalid = (wr_state_r == rtc_date_pkg::WR_RESP);
  assign bresp = bresp_r;
  assign arready = run && !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign aw_fire = awvalid && awready;
  assign w_fire = wvalid && wready;
  assign ar_fire = arvalid && arready;
  // address and data may arrive in either order; use the held copy
  assign wr_addr = aw_got_r ? waddr_r : awaddr;
  assign wr_byte = w_got_r ? wbyte_r : wdata[7:0];
  assign wr_lane = w_got_r ? wlane_r : wstrb[0];
  assign wr_do = run && (wr_state_r == rtc_date_pkg::WR_IDLE) &&
                 (aw_got_r || aw_fire) && (w_got_r || w_fire);
  assign wr_sel = reg_dec(wr_addr);
  assign rd_sel = reg_dec(araddr);
  // a locked clock turns the date writes into no-ops, still OKAY
  assign weekday_wr = wr_do && wr_lane && !clock_locked &&
                      (wr_sel == rtc_date_pkg::SEL_WEEKDAY);
  assign month_wr = wr_do && wr_lane && !clock_locked &&
                    (wr_sel == rtc_date_pkg::SEL_MONTH);
  assign year_wr = wr_do && wr_lane && !clock_locked &&
                   (wr_sel == rtc_date_pkg::SEL_YEAR);
  // alarm seconds ignore the lock
  assign alarm_wr = wr_do && wr_lane &&
                    (wr_sel == rtc_date_pkg::SEL_ALARM);
  // write sequencer: collect both halves, then answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_state_r <= rtc_date_pkg::WR_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bresp_r <= `RTC_RESP_OKAY;
    end else if (clk_en) begin
      case (wr_state_r)
        rtc_date_pkg::WR_IDLE: begin
          if (wr_do) begin
            wr_state_r <= rtc_date_pkg::WR_RESP;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            // unmapped addresses answer an error, nothing stored
            bresp_r <= (wr_sel == rtc_date_pkg::SEL_NONE) ?
                       `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
          end else begin
            if (aw_fire) begin
              aw_got_r <= 1'b1;
            end
            if (w_fire) begin
              w_got_r <= 1'b1;
            end
          end
        end
        rtc_date_pkg::WR_RESP: begin
          if (bready) begin
            wr_state_r <= rtc_date_pkg::WR_IDLE;
          end
        end
        default: begin
          wr_state_r <= rtc_date_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // held copies of whichever write half came first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waddr_r <= '0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (clk_en) begin
      if (aw_fire) begin
        waddr_r <= awaddr;
      end
      if (w_fire) begin
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0];
      end
    end
  end

  // read channel: data registered on the same edge that takes the address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RTC_RESP_OKAY;
    end else if (clk_en) begin
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rresp_r <= `RTC_RESP_OKAY;
        case (rd_sel)
          rtc_date_pkg::SEL_WEEKDAY: begin
            rdata_r <= {29'h0, weekday_r};
          end
          rtc_date_pkg::SEL_MONTH: begin
            rdata_r <= {27'h0, month_r};
          end
          rtc_date_pkg::SEL_YEAR: begin
            rdata_r <= {24'h0, year_r};
          end
          rtc_date_pkg::SEL_ALARM: begin
            rdata_r <= {24'h0, alarm_sec_r};
          end
          default: begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RTC_RESP_SLVERR;
          end
        endcase
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // step limits follow the coding select
  assign step_cur[0] = {5'h00, weekday_r};
  assign step_cur[1] = {3'h0, month_r};
  assign step_cur[2] = year_r;
  assign step_min[0] = `RTC_WEEKDAY_MIN;
  assign step_min[1] = `RTC_MONTH_MIN;
  assign step_min[2] = `RTC_YEAR_MIN;
  assign step_max[0] = `RTC_WEEKDAY_MAX;
  assign step_max[1] = bcd_en ? `RTC_MONTH_MAX_BCD : `RTC_MONTH_MAX_BIN;
  assign step_max[2] = bcd_en ? `RTC_YEAR_MAX_BCD : `RTC_YEAR_MAX_BIN;

  // one stepper per field
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_step
      rtc_field_step u_step (
        .cur(step_cur[g]),
        .bcd_mode(bcd_en),
        .min_val(step_min[g]),
        .max_val(step_max[g]),
        .nxt_val(step_nxt[g]),
        .at_max(step_wrap[g])
      );
    end
  endgenerate

  // a software write in the same cycle as a tick wins, since software
  // only writes while setting the clock
  assign year_carry = month_tick && step_wrap[1] && !month_wr;
  // weekday count: no reset branch, so the value survives reset
  always_ff @(posedge clk) begin
    if (run) begin
      if (weekday_wr) begin
        weekday_r <= wr_byte[`RTC_WEEKDAY_W-1:0];
      end else if (day_tick) begin
        weekday_r <= step_nxt[0][`RTC_WEEKDAY_W-1:0];
      end
    end
  end

  // month count; the top three bits are not stored and read zero
  always_ff @(posedge clk) begin
    if (run) begin
      if (month_wr) begin
        month_r <= wr_byte[`RTC_MONTH_W-1:0];
      end else if (month_tick) begin
        month_r <= step_nxt[1][`RTC_MONTH_W-1:0];
      end
    end
  end

  // year count, all eight bits kept for decimal tens
  always_ff @(posedge clk) begin
    if (run) begin
      if (year_wr) begin
        year_r <= wr_byte;
      end else if (year_carry) begin
        year_r <= step_nxt[2];
      end
    end
  end

  // alarm seconds value, kept through reset
  always_ff @(posedge clk) begin
    if (run) begin
      if (alarm_wr) begin
        alarm_sec_r <= wr_byte;
      end
    end
  end

  // register images for the rest of the unit
  assign date = '{weekday: {5'h00, weekday_r}, month: {3'h0, month_r},
                  year: year_r, alarm_sec: alarm_sec_r};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_reset_keeps: assert property (
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> $stable(weekday_r) && $stable(month_r) && $stable(year_r))
    else $error("date count changed during reset");
  chk_lock_blocks: assert property (
    (wr_do && clock_locked && !day_tick && !month_tick) |=>
    $stable(weekday_r) && $stable(month_r) && $stable(year_r))
    else $error("date count written while locked");
  chk_weekday_write: assert property (
    (wr_do && wr_lane && !clock_locked &&
     wr_sel == rtc_date_pkg::SEL_WEEKDAY) |=>
    weekday_r == $past(wr_byte[2:0]))
    else $error("weekday write not stored");
  chk_weekday_wrap: assert property (
    (day_tick && run && !weekday_wr && weekday_r == 3'h7) |=>
    weekday_r == 3'h1)
    else $error("weekday did not wrap to one");
  chk_weekday_upper: assert property (
    (ar_fire && rd_sel == rtc_date_pkg::SEL_WEEKDAY) |=>
    rvalid && rdata[31:3] == 29'h0)
    else $error("weekday upper bits not zero");
  chk_month_wrap: assert property (
    (month_tick && run && !month_wr && !year_wr && bcd_en &&
     month_r == 5'h12 && year_r == 8'h19) |=>
    month_r == 5'h01 && year_r == 8'h20)
    else $error("decimal month wrap or year carry wrong");
  chk_year_wrap: assert property (
    (year_carry && run && !year_wr && bcd_en && year_r == 8'h99) |=>
    year_r == 8'h00)
    else $error("decimal year did not wrap to zero");
  chk_bcd_digit: assert property (
    (month_tick && run && !month_wr && bcd_en && month_r == 5'h09) |=>
    month_r == 5'h10 ##1 $stable(year_r) || month_tick)
    else $error("decimal month ones did not carry");
  chk_bin_month: assert property (
    (month_tick && run && !month_wr && !bcd_en && month_r == 5'h09) |=>
    month_r == 5'h0a)
    else $error("binary month step wrong");
  chk_bin_year: assert property (
    (year_carry && run && !year_wr && !bcd_en && year_r == 8'h63) |=>
    year_r == 8'h00)
    else $error("binary year did not wrap at 0x63");
  chk_alarm_write: assert property (
    (wr_do && wr_lane && wr_sel == rtc_date_pkg::SEL_ALARM) |=>
    alarm_sec_r == $past(wr_byte))
    else $error("alarm seconds write lost");
  chk_write_answer: assert property (
    wr_do |=> bvalid [*1] ##0 (bresp == `RTC_RESP_OKAY ||
    bresp == `RTC_RESP_SLVERR))
    else $error("write not answered next cycle");

endmodule : rtc_date_regs

//--- tb/rtc_date_regs_tb.sv
/*
  Self-checking bench for the calendar date registers: writes and reads
  them over AXI4-Lite, pulses the day and month ticks, toggles coding and
  lock, and re-applies reset to see that the counts survive it.
  Assumes rtc_date_consts.svh and rtc_date_pkg are compiled before it.
*/
`include "rtc_date_consts.svh"

// compare two values, count it, report a mismatch at once
`define CHK(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end \
end

module rtc_date_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0; // 20 MHz system clock
  logic sys_rst = 1'b1; // synchronous reset, high
  logic clk_en = 1'b1; // clock enable, low freezes the block
  logic bcd_en = 1'b0; // coding select
  logic clock_locked = 1'b0; // lock of the date counts
  logic day_tick = 1'b0; // day rollover pulse
  logic month_tick = 1'b0; // month rollover pulse
  rtc_date_pkg::date_s date; // register images
  logic [15:0] awaddr = 16'h0000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [15:0] araddr = 16'h0000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  int fails = 0; // mismatches seen
  int comparisons = 0; // comparisons made
  logic [7:0] lock_val [3]; // values held across lock and reset

  // half period of 25 ns gives 50 ns
  always #25 clk = ~clk;

  // device under test; clk_en is driven so the freeze is exercised
  rtc_date_regs #(.ADDR_W(16)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bcd_en(bcd_en),
    .clock_locked(clock_locked), .day_tick(day_tick),
    .month_tick(month_tick), .date(date),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // byte address of a register index: four bytes per index
  function automatic logic [15:0] ba(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  // verdict and end of run; the only place that finishes
  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // one write; address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [15:0] a, input logic [7:0] d,
                        input logic [1:0] er);
    int n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 40) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      // the answer only counts once both halves were taken
      if (bvalid === 1'b1 && aw_ok && w_ok) begin
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
        // one edge passes so the next call never re-raises bready at once
        @(posedge clk);
        return;
      end
    end
    fails++;
    test_done();
  endtask : axi_wr

  // one read, checked against an expected byte and response
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
                        input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 40) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1 && !arvalid) begin
        rready <= 1'b0;
        `CHK("rdata", {24'h00_0000, e}, rdata)
        `CHK("rresp", er, rresp)
        // one edge passes so the next call never re-raises rready at once
        @(posedge clk);
        return;
      end
    end
    fails++;
    test_done();
  endtask : rd_chk

  // one-cycle tick pulse on day (sel 0) or month (sel 1)
  task automatic tick(input logic sel);
    if (sel) begin
      month_tick <= 1'b1;
    end else begin
      day_tick <= 1'b1;
    end
    @(posedge clk);
    day_tick <= 1'b0;
    month_tick <= 1'b0;
    @(posedge clk);
  endtask : tick

  // write month and year, then let the month roll over
  task automatic month_roll(input logic [7:0] m, input logic [7:0] y);
    axi_wr(ba(`RTC_IDX_MONTH), m, `RTC_RESP_OKAY);
    axi_wr(ba(`RTC_IDX_YEAR), y, `RTC_RESP_OKAY);
    tick(1'b1);
  endtask : month_roll

  // reset held for six cycles, released just after an edge
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  initial begin
    lock_val = '{8'h03, 8'h04, 8'h05};
    do_reset();
    // binary coding, unlocked; reserved weekday bits stay zero
    axi_wr(ba(`RTC_IDX_WEEKDAY), 8'hff, `RTC_RESP_OKAY);
    rd_chk(ba(`RTC_IDX_WEEKDAY), 8'h07, `RTC_RESP_OKAY);
    // weekday wraps from seven to its lowest count, one
    axi_wr(ba(`RTC_IDX_WEEKDAY), 8'h07, `RTC_RESP_OKAY);
    tick(1'b0);
    rd_chk(ba(`RTC_IDX_WEEKDAY), 8'h01, `RTC_RESP_OKAY);
    tick(1'b0);
    rd_chk(ba(`RTC_IDX_WEEKDAY), 8'h02, `RTC_RESP_OKAY);
    // binary month past twelve: back to one, year carries
    month_roll(8'h0c, 8'h62);
    rd_chk(ba(`RTC_IDX_MONTH), 8'h01, `RTC_RESP_OKAY);
    rd_chk(ba(`RTC_IDX_YEAR), 8'h63, `RTC_RESP_OKAY);
    tick(1'b1);
    rd_chk(ba(`RTC_IDX_MONTH), 8'h02, `RTC_RESP_OKAY);
    // binary nine steps to 0ah, not to a decimal ten
    month_roll(8'h09, 8'h10);
    rd_chk(ba(`RTC_IDX_MONTH), 8'h0a, `RTC_RESP_OKAY);
    // binary year at 63h wraps to zero
    month_roll(8'h0c, 8'h63);
    rd_chk(ba(`RTC_IDX_YEAR), 8'h00, `RTC_RESP_OKAY);
    // decimal coding: digit carries
    bcd_en <= 1'b1;
    month_roll(8'h09, 8'h00);
    rd_chk(ba(`RTC_IDX_MONTH), 8'h10, `RTC_RESP_OKAY);
    rd_chk(ba(`RTC_IDX_YEAR), 8'h00, `RTC_RESP_OKAY);
    month_roll(8'h12, 8'h19);
    rd_chk(ba(`RTC_IDX_MONTH), 8'h01, `RTC_RESP_OKAY);
    rd_chk(ba(`RTC_IDX_YEAR), 8'h20, `RTC_RESP_OKAY);
    month_roll(8'h12, 8'h99);
    rd_chk(ba(`RTC_IDX_YEAR), 8'h00, `RTC_RESP_OKAY);
    axi_wr(ba(`RTC_IDX_WEEKDAY), 8'h07, `RTC_RESP_OKAY);
    tick(1'b0);
    rd_chk(ba(`RTC_IDX_WEEKDAY), 8'h01, `RTC_RESP_OKAY);
    // frozen: a day tick while clk_en is low leaves the weekday alone
    clk_en <= 1'b0;
    tick(1'b0);
    clk_en <= 1'b1;
    rd_chk(ba(`RTC_IDX_WEEKDAY), 8'h01, `RTC_RESP_OKAY);
    // locked: the three counts ignore writes, alarm still takes them
    for (int i = 0; i < 3; i++) begin
      axi_wr(ba(`RTC_IDX_WEEKDAY + 12'(i)), lock_val[i], `RTC_RESP_OKAY);
    end
    clock_locked <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axi_wr(ba(`RTC_IDX_WEEKDAY + 12'(i)), 8'h06, `RTC_RESP_OKAY);
      rd_chk(ba(`RTC_IDX_WEEKDAY + 12'(i)), lock_val[i],
             `RTC_RESP_OKAY);
    end
    axi_wr(ba(`RTC_IDX_ALARM_SEC), 8'h59, `RTC_RESP_OKAY);
    rd_chk(ba(`RTC_IDX_ALARM_SEC), 8'h59, `RTC_RESP_OKAY);
    // unlocked again, writes land
    clock_locked <= 1'b0;
    axi_wr(ba(`RTC_IDX_YEAR), 8'h05, `RTC_RESP_OKAY);
    rd_chk(ba(`RTC_IDX_YEAR), 8'h05, `RTC_RESP_OKAY);
    // a second reset keeps every count and the alarm value
    do_reset();
    for (int i = 0; i < 3; i++) begin
      rd_chk(ba(`RTC_IDX_WEEKDAY + 12'(i)), lock_val[i],
             `RTC_RESP_OKAY);
    end
    rd_chk(ba(`RTC_IDX_ALARM_SEC), 8'h59, `RTC_RESP_OKAY);
    `CHK("date", {8'h03, 8'h04, 8'h05, 8'h59}, date)
    // unmapped place: error answer, nothing read back
    axi_wr(ba(12'hf3a), 8'h11, `RTC_RESP_SLVERR);
    rd_chk(ba(12'hf3a), 8'h00, `RTC_RESP_SLVERR);
    test_done();
  end
endmodule : rtc_date_regs_tb
